/* File: rtl/aid_datapath.sv */
// Summary of operation
// - decimal adjust writes accumulator plus 00h, 06h, 60h or 66h to memory.
// - add six per nibble above nine or with its carry; only carry changes.
// - decrement memory byte into memory or accumulator; zero flag follows result.
// - increment memory byte into memory or accumulator; zero flag follows result.
// - power down stops, clock off, clears watchdog, sets power-down, clears timeout.
// - jump loads program counter, takes two instruction cycles, no flags.
// - moves copy memory, immediate or accumulator without touching flags.
// - no-operation changes nothing and proceeds to the next instruction.
// - OR accumulator with memory or immediate; result to acc or memory; zero only.
// - returns pop the program counter; immediate form also loads accumulator.
// - interrupt return pops program counter and sets master interrupt enable.
// - a pending interrupt at interrupt return is serviced before the main program.
// - rotate left, bit 7 into bit 0, to memory or accumulator, no flags.
// - rotate left through carry: old carry to bit 0, bit 7 to carry.
// - rotate right, bit 0 into bit 7, to memory or accumulator, no flags.
// - rotate right through carry: old carry to bit 7, bit 0 to carry.
// - subtract operand and inverted carry from accumulator; result to acc or memory.
// - after subtract with borrow, carry is 0 if negative, else 1.
// - subtract with borrow updates overflow, zero, aux carry, carry, signed, carry-zero.
// - decrement-and-skip writes back and skips next instruction when zero, no flags.
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module aid_datapath
  import aid_pkg::*;
(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  // instruction issue
  input  wire logic               instr_valid_i,
  input  wire logic [4:0]         instr_op_i,
  input  wire logic [MADDR_W-1:0] instr_addr_i,
  input  wire logic [DATA_W-1:0]  instr_imm_i,
  input  wire logic [PC_W-1:0]    instr_target_i,
  output logic                    instr_ready_o,
  output logic                    instr_done_o,
  // data memory
  output logic [MADDR_W-1:0]      mem_addr_o,
  input  wire logic [DATA_W-1:0]  mem_rdata_i,
  output logic                    mem_we_o,
  output logic [DATA_W-1:0]       mem_wdata_o,
  // program counter stack
  output logic                    stack_pop_o,
  input  wire logic [PC_W-1:0]    stack_top_i,
  output logic [PC_W-1:0]         pc_o,
  // interrupt and power
  input  wire logic               int_pending_i,
  output logic                    int_take_o,
  output logic                    master_interrupt_enable_o,
  input  wire logic               wdt_timeout_i,
  output logic                    wdt_clear_o,
  output logic                    sys_clk_run_o,
  input  wire logic               wake_i,
  // software register port
  input  wire logic [RADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0]  reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic [DATA_W-1:0]       reg_rdata_o
);

  aid_state_e           state_ff;
  aid_state_e           nxt_state;
  aid_op_e              op_ff;
  logic [MADDR_W-1:0]   addr_ff;
  logic [DATA_W-1:0]    imm_ff;
  logic [PC_W-1:0]      target_ff;
  logic [DATA_W-1:0]    acc_ff;
  logic [DATA_W-1:0]    status_ff;
  logic                 emi_ff;
  logic [PC_W-1:0]      pc_ff;
  logic                 mem_we_ff;
  logic [DATA_W-1:0]    mem_wdata_ff;
  logic                 wdt_clear_ff;
  logic                 int_take_ff;
  logic                 done_ff;
  logic [DATA_W-1:0]    rdata_ff;

  // execute-stage results
  logic [DATA_W-1:0]    res;
  logic                 wr_acc;
  logic                 wr_mem;
  logic                 upd_z;
  logic                 upd_c;
  logic                 new_c;
  logic                 upd_sub;
  logic                 need_dummy;
  logic [PC_W-1:0]      nxt_pc;
  logic                 do_pop;

  logic [DATA_W-1:0]    opnd;
  logic [DATA_W-1:0]    sub_src;
  logic                 borrow_in;
  logic [DATA_W:0]      sub_full;
  logic [4:0]           sub_low;
  logic [DATA_W-1:0]    adj;
  logic [DATA_W:0]      adj_full;
  logic                 sub_ov;
  logic                 sub_z;
  logic                 exec;

  assign exec = (state_ff == ST_EXEC);
  assign opnd = mem_rdata_i;

  // subtract with borrow shared by the three forms
  always_comb begin
    sub_src = (op_ff == OP_SUB_BORROW_IMM_ACC) ? imm_ff : opnd;
    borrow_in = ~status_ff[ST_C];
    sub_full = {1'b0, acc_ff} - {1'b0, sub_src} - {8'h00, borrow_in};
    sub_low = {1'b0, acc_ff[3:0]} - {1'b0, sub_src[3:0]} - {4'h0, borrow_in};
    sub_ov = (acc_ff[7] != sub_src[7]) && (sub_full[7] != acc_ff[7]);
    sub_z = (sub_full[7:0] == 8'h00);
  end

  // decimal adjust correction choice
  always_comb begin
    adj = ADJ_NONE;
    if (((acc_ff[3:0] > BCD_MAX) || status_ff[ST_AC]) &&
        ((acc_ff[7:4] > BCD_MAX) || status_ff[ST_C])) begin
      adj = ADJ_BOTH;
    end else if ((acc_ff[3:0] > BCD_MAX) || status_ff[ST_AC]) begin
      adj = ADJ_LO;
    end else if ((acc_ff[7:4] > BCD_MAX) || status_ff[ST_C]) begin
      adj = ADJ_HI;
    end
    adj_full = {1'b0, acc_ff} + {1'b0, adj};
  end

  always_comb begin
    res = acc_ff;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    new_c = status_ff[ST_C];
    upd_sub = 1'b0;
    need_dummy = 1'b0;
    nxt_pc = pc_ff + PC_STEP;
    do_pop = 1'b0;
    case (op_ff)
      OP_DECIMAL_ADJUST: begin
        res = adj_full[7:0];
        wr_mem = 1'b1;
        upd_c = 1'b1;
        new_c = status_ff[ST_C] | adj_full[8];
      end
      OP_INCREMENT_MEMORY, OP_INCREMENT_TO_ACC: begin
        res = opnd + 8'h01;
        wr_mem = (op_ff == OP_INCREMENT_MEMORY);
        wr_acc = (op_ff == OP_INCREMENT_TO_ACC);
        upd_z = 1'b1;
      end
      OP_DECREMENT_MEMORY, OP_DECREMENT_TO_ACC: begin
        res = opnd - 8'h01;
        wr_mem = (op_ff == OP_DECREMENT_MEMORY);
        wr_acc = (op_ff == OP_DECREMENT_TO_ACC);
        upd_z = 1'b1;
      end
      OP_MOVE_MEM_TO_ACC: begin
        res = opnd;
        wr_acc = 1'b1;
      end
      OP_MOVE_IMM_TO_ACC: begin
        res = imm_ff;
        wr_acc = 1'b1;
      end
      OP_MOVE_ACC_TO_MEM: begin
        res = acc_ff;
        wr_mem = 1'b1;
      end
      OP_OR_MEM_TO_ACC, OP_OR_TO_MEMORY: begin
        res = acc_ff | opnd;
        wr_acc = (op_ff == OP_OR_MEM_TO_ACC);
        wr_mem = (op_ff == OP_OR_TO_MEMORY);
        upd_z = 1'b1;
      end
      OP_OR_IMM_TO_ACC: begin
        res = acc_ff | imm_ff;
        wr_acc = 1'b1;
        upd_z = 1'b1;
      end
      OP_ROTATE_LEFT_MEMORY, OP_ROTATE_LEFT_TO_ACC: begin
        res = {opnd[6:0], opnd[7]};
        wr_mem = (op_ff == OP_ROTATE_LEFT_MEMORY);
        wr_acc = (op_ff == OP_ROTATE_LEFT_TO_ACC);
      end
      OP_ROT_LEFT_CARRY_MEM, OP_ROT_LEFT_CARRY_ACC: begin
        res = {opnd[6:0], status_ff[ST_C]};
        wr_mem = (op_ff == OP_ROT_LEFT_CARRY_MEM);
        wr_acc = (op_ff == OP_ROT_LEFT_CARRY_ACC);
        upd_c = 1'b1;
        new_c = opnd[7];
      end
      OP_ROTATE_RIGHT_MEMORY, OP_ROTATE_RIGHT_TO_ACC: begin
        res = {opnd[0], opnd[7:1]};
        wr_mem = (op_ff == OP_ROTATE_RIGHT_MEMORY);
        wr_acc = (op_ff == OP_ROTATE_RIGHT_TO_ACC);
      end
      OP_ROT_RIGHT_CARRY_MEM, OP_ROT_RIGHT_CARRY_ACC: begin
        res = {status_ff[ST_C], opnd[7:1]};
        wr_mem = (op_ff == OP_ROT_RIGHT_CARRY_MEM);
        wr_acc = (op_ff == OP_ROT_RIGHT_CARRY_ACC);
        upd_c = 1'b1;
        new_c = opnd[0];
      end
      OP_SUB_BORROW_MEM_ACC, OP_SUB_BORROW_IMM_ACC, OP_SUB_BORROW_TO_MEMORY: begin
        res = sub_full[7:0];
        wr_mem = (op_ff == OP_SUB_BORROW_TO_MEMORY);
        wr_acc = (op_ff != OP_SUB_BORROW_TO_MEMORY);
        upd_sub = 1'b1;
      end
      OP_DEC_SKIP_IF_ZERO: begin
        res = opnd - 8'h01;
        wr_mem = 1'b1;
        if (res == 8'h00) begin
          need_dummy = 1'b1;
          nxt_pc = pc_ff + PC_SKIP;
        end
      end
      OP_JUMP: begin
        nxt_pc = target_ff;
        need_dummy = 1'b1;
      end
      OP_RETURN: begin
        nxt_pc = stack_top_i;
        do_pop = 1'b1;
      end
      OP_RETURN_IMM: begin
        nxt_pc = stack_top_i;
        do_pop = 1'b1;
        res = imm_ff;
        wr_acc = 1'b1;
      end
      OP_INTERRUPT_RETURN: begin
        nxt_pc = stack_top_i;
        do_pop = 1'b1;
      end
      default: begin
        res = acc_ff;
      end
    endcase
  end

  // sequencer: one execute cycle per instruction unless a dummy is needed
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (instr_valid_i) begin
          nxt_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (op_ff == OP_POWER_DOWN) begin
          nxt_state = ST_HALTED;
        end else if (need_dummy) begin
          nxt_state = ST_DUMMY;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      ST_DUMMY: begin
        nxt_state = ST_IDLE;
      end
      ST_HALTED: begin
        if (wake_i) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // instruction capture; an unknown code executes as no-operation
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      op_ff <= OP_NOP;
      addr_ff <= '0;
      imm_ff <= '0;
      target_ff <= PC_RST;
    end else if (state_ff == ST_IDLE && instr_valid_i) begin
      op_ff <= aid_op_e'(instr_op_i);
      addr_ff <= instr_addr_i;
      imm_ff <= instr_imm_i;
      target_ff <= instr_target_i;
    end
  end

  // accumulator: execution wins over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      acc_ff <= ACC_RST;
    end else if (exec && wr_acc) begin
      acc_ff <= res;
    end else if (reg_wr_i && reg_addr_i == REG_ACC) begin
      acc_ff <= reg_wdata_i;
    end
  end

  // status flags; hardware events win over software clears
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      status_ff <= STATUS_RST;
    end else begin
      if (reg_wr_i && reg_addr_i == REG_STATUS) begin
        status_ff <= reg_wdata_i;
      end
      if (wdt_timeout_i) begin
        status_ff[ST_TO] <= 1'b1;
      end
      if (exec) begin
        if (upd_z) begin
          status_ff[ST_Z] <= (res == 8'h00);
        end
        if (upd_c) begin
          status_ff[ST_C] <= new_c;
        end
        if (upd_sub) begin
          status_ff[ST_C] <= ~sub_full[8];
          status_ff[ST_AC] <= ~sub_low[4];
          status_ff[ST_Z] <= sub_z;
          status_ff[ST_OV] <= sub_ov;
          status_ff[ST_SC] <= ~(sub_full[7] ^ sub_ov);
          status_ff[ST_CZ] <= sub_z & status_ff[ST_Z];
        end
        if (op_ff == OP_POWER_DOWN) begin
          status_ff[ST_PDF] <= 1'b1;
          status_ff[ST_TO] <= 1'b0;
        end
      end
    end
  end

  // master interrupt enable
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      emi_ff <= 1'b0;
    end else if (exec && op_ff == OP_INTERRUPT_RETURN) begin
      emi_ff <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
      emi_ff <= reg_wdata_i[CT_EMI];
    end
  end

  // program counter advances when the execute cycle retires
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pc_ff <= PC_RST;
    end else if (exec && op_ff != OP_POWER_DOWN) begin
      pc_ff <= nxt_pc;
    end else if (exec) begin
      pc_ff <= pc_ff + PC_STEP;
    end
  end

  // memory write lands one clock after execute, address still held
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mem_we_ff <= 1'b0;
      mem_wdata_ff <= '0;
    end else begin
      mem_we_ff <= exec && wr_mem;
      mem_wdata_ff <= res;
    end
  end

  // interrupt take on return is flagged so the pending routine runs first
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      int_take_ff <= 1'b0;
      wdt_clear_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      int_take_ff <= exec && op_ff == OP_INTERRUPT_RETURN && int_pending_i;
      wdt_clear_ff <= exec && op_ff == OP_POWER_DOWN;
      done_ff <= (exec && !need_dummy) || state_ff == ST_DUMMY;
    end
  end

  // software read port, data one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_ff <= '0;
    end else if (reg_rd_i) begin
      if (reg_addr_i == REG_ACC) begin
        rdata_ff <= acc_ff;
      end else if (reg_addr_i == REG_STATUS) begin
        rdata_ff <= status_ff;
      end else if (reg_addr_i == REG_CTRL) begin
        rdata_ff <= {7'h00, emi_ff};
      end else if (reg_addr_i == REG_PC_LO) begin
        rdata_ff <= pc_ff[7:0];
      end else if (reg_addr_i == REG_PC_HI) begin
        rdata_ff <= {2'h0, pc_ff[13:8]};
      end else if (reg_addr_i == REG_CORE) begin
        rdata_ff <= {4'h0, state_ff};
      end else begin
        rdata_ff <= 8'h00;
      end
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign instr_ready_o = (state_ff == ST_IDLE);
  assign instr_done_o = done_ff;
  assign mem_addr_o = addr_ff;
  assign mem_we_o = mem_we_ff;
  assign mem_wdata_o = mem_wdata_ff;
  assign stack_pop_o = exec && do_pop;
  assign pc_o = pc_ff;
  assign int_take_o = int_take_ff;
  assign master_interrupt_enable_o = emi_ff;
  assign wdt_clear_o = wdt_clear_ff;
  // clock stays stopped until wake; register contents are simply held
  assign sys_clk_run_o = (state_ff != ST_HALTED);
  assign reg_rdata_o = rdata_ff;

endmodule

/* File: rtl/aid_pkg.sv */
package aid_pkg;

  // datapath widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned MADDR_W = 11;
  localparam int unsigned PC_W = 14;
  localparam int unsigned RADDR_W = 3;

  // register offsets on the software port
  localparam logic [2:0] REG_ACC = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_CTRL = 3'h2;
  localparam logic [2:0] REG_PC_LO = 3'h3;
  localparam logic [2:0] REG_PC_HI = 3'h4;
  localparam logic [2:0] REG_CORE = 3'h5;

  // status register bit positions
  localparam int unsigned ST_C = 0;
  localparam int unsigned ST_AC = 1;
  localparam int unsigned ST_Z = 2;
  localparam int unsigned ST_OV = 3;
  localparam int unsigned ST_PDF = 4;
  localparam int unsigned ST_TO = 5;
  localparam int unsigned ST_SC = 6;
  localparam int unsigned ST_CZ = 7;

  // control register bit positions
  localparam int unsigned CT_EMI = 0;

  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 14'h0000;

  // decimal adjust
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [7:0] ADJ_NONE = 8'h00;
  localparam logic [7:0] ADJ_LO = 8'h06;
  localparam logic [7:0] ADJ_HI = 8'h60;
  localparam logic [7:0] ADJ_BOTH = 8'h66;

  // program counter steps
  localparam logic [PC_W-1:0] PC_STEP = 14'h0001;
  localparam logic [PC_W-1:0] PC_SKIP = 14'h0002;

  typedef enum logic [4:0] {
    OP_NOP                   = 5'h00,
    OP_DECIMAL_ADJUST        = 5'h01,
    OP_INCREMENT_MEMORY      = 5'h02,
    OP_INCREMENT_TO_ACC      = 5'h03,
    OP_DECREMENT_MEMORY      = 5'h04,
    OP_DECREMENT_TO_ACC      = 5'h05,
    OP_MOVE_MEM_TO_ACC       = 5'h06,
    OP_MOVE_IMM_TO_ACC       = 5'h07,
    OP_MOVE_ACC_TO_MEM       = 5'h08,
    OP_OR_MEM_TO_ACC         = 5'h09,
    OP_OR_IMM_TO_ACC         = 5'h0a,
    OP_OR_TO_MEMORY          = 5'h0b,
    OP_ROTATE_LEFT_MEMORY    = 5'h0c,
    OP_ROTATE_LEFT_TO_ACC    = 5'h0d,
    OP_ROT_LEFT_CARRY_MEM    = 5'h0e,
    OP_ROT_LEFT_CARRY_ACC    = 5'h0f,
    OP_ROTATE_RIGHT_MEMORY   = 5'h10,
    OP_ROTATE_RIGHT_TO_ACC   = 5'h11,
    OP_ROT_RIGHT_CARRY_MEM   = 5'h12,
    OP_ROT_RIGHT_CARRY_ACC   = 5'h13,
    OP_SUB_BORROW_MEM_ACC    = 5'h14,
    OP_SUB_BORROW_IMM_ACC    = 5'h15,
    OP_SUB_BORROW_TO_MEMORY  = 5'h16,
    OP_DEC_SKIP_IF_ZERO      = 5'h17,
    OP_JUMP                  = 5'h18,
    OP_RETURN                = 5'h19,
    OP_RETURN_IMM            = 5'h1a,
    OP_INTERRUPT_RETURN      = 5'h1b,
    OP_POWER_DOWN            = 5'h1c
  } aid_op_e;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_EXEC   = 4'b0010,
    ST_DUMMY  = 4'b0100,
    ST_HALTED = 4'b1000
  } aid_state_e;

endpackage

/* File: sim/aid_mem_model.sv */
`timescale 1ns/1ps
module aid_mem_model
  import aid_pkg::*;
(
  // clock
  input  wire logic               clk_i,
  // data memory side
  input  wire logic [MADDR_W-1:0] mem_addr_i,
  input  wire logic               mem_we_i,
  input  wire logic [DATA_W-1:0]  mem_wdata_i,
  output logic [DATA_W-1:0]       mem_rdata_o,
  // program counter stack side
  input  wire logic               stack_pop_i,
  output logic [PC_W-1:0]         stack_top_o
);
  logic [DATA_W-1:0] mem_q [2048];
  logic [PC_W-1:0]   stk_q [4];
  logic [1:0]        sp_q = 2'h0;

  // read is asynchronous: the datapath samples it within the execute cycle
  assign mem_rdata_o = mem_q[mem_addr_i];
  assign stack_top_o = stk_q[sp_q];

  // plain always so the bench may preload contents between instructions
  always @(posedge clk_i) begin
    if (mem_we_i) begin
      mem_q[mem_addr_i] <= mem_wdata_i;
    end
    if (stack_pop_i) begin
      sp_q <= sp_q - 2'h1;
    end
  end
endmodule

/* File: sim/aid_datapath_checker.sv */
`timescale 1ns/1ps
module aid_datapath_checker
  import aid_pkg::*;
(
  input wire logic               clk_i,
  input wire logic               reset_i,
  input wire logic               instr_valid_i,
  input wire logic [4:0]         instr_op_i,
  input wire logic [PC_W-1:0]    instr_target_i,
  input wire logic               instr_ready_o,
  input wire logic               instr_done_o,
  input wire logic [DATA_W-1:0]  mem_rdata_i,
  input wire logic               mem_we_o,
  input wire logic [DATA_W-1:0]  mem_wdata_o,
  input wire logic               stack_pop_o,
  input wire logic [PC_W-1:0]    stack_top_i,
  input wire logic [PC_W-1:0]    pc_o,
  input wire logic               int_pending_i,
  input wire logic               int_take_o,
  input wire logic               master_interrupt_enable_o,
  input wire logic               wdt_clear_o,
  input wire logic               sys_clk_run_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  logic take;
  assign take = instr_valid_i && instr_ready_o;

  a_done_single: assert property (take && !(instr_op_i inside {OP_JUMP, OP_DEC_SKIP_IF_ZERO,
    OP_POWER_DOWN}) |-> ##2 instr_done_o) else $error("single cycle op late");
  a_jump_pc: assert property (take && instr_op_i == OP_JUMP |-> ##2
    (pc_o == $past(instr_target_i, 2)) ##1 instr_done_o) else $error("jump timing");
  a_pop_return: assert property (stack_pop_o |=> pc_o == $past(stack_top_i))
    else $error("return target wrong");
  a_interrupt_return_emi: assert property (take && instr_op_i == OP_INTERRUPT_RETURN |-> ##2
    master_interrupt_enable_o) else $error("enable not set");
  a_interrupt_return_take: assert property (take && instr_op_i == OP_INTERRUPT_RETURN ##1 int_pending_i
    |=> int_take_o) else $error("pending not taken");
  a_halt_entry: assert property (take && instr_op_i == OP_POWER_DOWN |-> ##2
    (!sys_clk_run_o && wdt_clear_o)) else $error("halt entry");
  a_halted_stop: assert property (!sys_clk_run_o |-> !instr_ready_o && !mem_we_o)
    else $error("activity while halted");
  a_inc_write: assert property (take && instr_op_i == OP_INCREMENT_MEMORY |-> ##2
    (mem_we_o && mem_wdata_o == $past(mem_rdata_i) + 8'h01)) else $error("inc data");
  a_acc_no_write: assert property (take && instr_op_i inside {OP_INCREMENT_TO_ACC,
    OP_DECREMENT_TO_ACC, OP_ROTATE_LEFT_TO_ACC, OP_ROTATE_RIGHT_TO_ACC} |-> ##2 !mem_we_o)
    else $error("memory written");
  a_skip_len: assert property (take && instr_op_i == OP_DEC_SKIP_IF_ZERO ##1
    mem_rdata_i == 8'h01 |-> ##1 !instr_done_o ##1 instr_done_o) else $error("skip");

  c_jump: cover property (take && instr_op_i == OP_JUMP);
  c_take: cover property (int_take_o);
  c_halt: cover property (!sys_clk_run_o ##1 sys_clk_run_o);
endmodule

bind aid_datapath aid_datapath_checker u_chk (.clk_i, .reset_i, .instr_valid_i, .instr_op_i,
  .instr_target_i, .instr_ready_o, .instr_done_o, .mem_rdata_i, .mem_we_o, .mem_wdata_o,
  .stack_pop_o, .stack_top_i, .pc_o, .int_pending_i, .int_take_o, .master_interrupt_enable_o,
  .wdt_clear_o, .sys_clk_run_o);

/* File: sim/aid_datapath_tb.sv */
`timescale 1ns/1ps
module aid_datapath_tb;
  import aid_pkg::*;
  // memory in, acc in, status in, immediate, acc out, memory out, status out, cycles
  typedef struct packed {logic [7:0] m0, a0, s0, imm, a1, m1, s1, cyc;} aid_vec_s;
  typedef struct {aid_op_e op; aid_vec_s v;} aid_row_s;
  aid_row_s rows [29] = '{
    '{OP_DECIMAL_ADJUST, 64'hee3c_0000_3c42_0001}, '{OP_DECIMAL_ADJUST, 64'heea2_0200_a208_0301},
    '{OP_DECIMAL_ADJUST, 64'hee12_0100_1272_0101}, '{OP_DECIMAL_ADJUST, 64'hee45_0000_4545_0001},
    '{OP_INCREMENT_MEMORY, 64'hff11_0000_1100_0401}, '{OP_INCREMENT_TO_ACC, 64'h7f00_0400_807f_0001},
    '{OP_DECREMENT_MEMORY, 64'h0122_0000_2200_0401}, '{OP_DECREMENT_TO_ACC, 64'h0033_0400_ff00_0001},
    '{OP_MOVE_MEM_TO_ACC, 64'ha500_0f00_a5a5_0f01}, '{OP_MOVE_IMM_TO_ACC, 64'h3c00_0f5a_5a3c_0f01},
    '{OP_MOVE_ACC_TO_MEM, 64'h00c3_0f00_c3c3_0f01}, '{OP_OR_MEM_TO_ACC, 64'h0000_0000_0000_0401},
    '{OP_OR_IMM_TO_ACC, 64'hff10_0401_11ff_0001}, '{OP_OR_TO_MEMORY, 64'h0ff0_0400_f0ff_0001},
    '{OP_ROTATE_LEFT_MEMORY, 64'h8100_0100_0003_0101}, '{OP_ROTATE_LEFT_TO_ACC, 64'hc000_0000_81c0_0001},
    '{OP_ROT_LEFT_CARRY_MEM, 64'h8000_0000_0000_0101}, '{OP_ROT_LEFT_CARRY_ACC, 64'h0100_0100_0301_0001},
    '{OP_ROTATE_RIGHT_MEMORY, 64'h0100_0000_0080_0001}, '{OP_ROTATE_RIGHT_TO_ACC, 64'h0300_0100_8103_0101},
    '{OP_ROT_RIGHT_CARRY_MEM, 64'h0100_0000_0000_0101}, '{OP_ROT_RIGHT_CARRY_ACC, 64'h0200_0100_8102_0001},
    '{OP_SUB_BORROW_MEM_ACC, 64'h0110_0100_0f01_4101}, '{OP_SUB_BORROW_IMM_ACC, 64'h5580_0000_7f55_0901},
    '{OP_SUB_BORROW_TO_MEMORY, 64'h0505_0500_0500_c701}, '{OP_SUB_BORROW_MEM_ACC, 64'h0100_0100_ff01_0001},
    '{OP_DEC_SKIP_IF_ZERO, 64'h0244_0400_4401_0401}, '{OP_DEC_SKIP_IF_ZERO, 64'h0144_0400_4400_0402},
    '{OP_NOP, 64'h9966_0c00_6699_0c01}};

  logic                clk_i = 1'b0;
  logic                reset_i = 1'b1;
  logic                instr_valid_i = 1'b0;
  logic [4:0]          instr_op_i = 5'h00;
  logic [MADDR_W-1:0]  instr_addr_i = 11'h000;
  logic [DATA_W-1:0]   instr_imm_i = 8'h00;
  logic [PC_W-1:0]     instr_target_i = 14'h0000;
  logic                int_pending_i = 1'b0;
  logic                wdt_timeout_i = 1'b0;
  logic                wake_i = 1'b0;
  logic [RADDR_W-1:0]  reg_addr_i = 3'h0;
  logic [DATA_W-1:0]   reg_wdata_i = 8'h00;
  logic                reg_wr_i = 1'b0;
  logic                reg_rd_i = 1'b0;
  logic                instr_ready_o, instr_done_o, mem_we_o, stack_pop_o, int_take_o;
  logic                master_interrupt_enable_o, wdt_clear_o, sys_clk_run_o;
  logic [MADDR_W-1:0]  mem_addr_o;
  logic [DATA_W-1:0]   mem_rdata_i, mem_wdata_o, reg_rdata_o, d;
  logic [PC_W-1:0]     stack_top_i, pc_o, pc0;
  int                  n_fail = 0;
  int                  total_checks = 0;
  int                  cyc;

  always #25 clk_i = ~clk_i;

  aid_datapath DUT (.clk_i, .reset_i, .instr_valid_i, .instr_op_i, .instr_addr_i, .instr_imm_i,
    .instr_target_i, .instr_ready_o, .instr_done_o, .mem_addr_o, .mem_rdata_i, .mem_we_o,
    .mem_wdata_o, .stack_pop_o, .stack_top_i, .pc_o, .int_pending_i, .int_take_o,
    .master_interrupt_enable_o, .wdt_timeout_i, .wdt_clear_o, .sys_clk_run_o, .wake_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
  aid_mem_model u_mem (.clk_i, .mem_addr_i(mem_addr_o), .mem_we_i(mem_we_o),
    .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i), .stack_pop_i(stack_pop_o),
    .stack_top_o(stack_top_i));

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // offers one instruction, counts clocks from the accept edge to done
  task automatic run(input aid_op_e op, input logic [10:0] a, input logic [7:0] imm,
                     input logic [13:0] tgt);
    @(posedge clk_i);
    instr_op_i <= op;
    instr_addr_i <= a;
    instr_imm_i <= imm;
    instr_target_i <= tgt;
    instr_valid_i <= 1'b1;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    cyc = 0;
    do begin
      @(posedge clk_i);
      #1 cyc++;
    end while (instr_done_o !== 1'b1 && cyc < 8);
    if (cyc >= 8) begin
      n_fail++;
      close_out();
    end
  endtask

  initial begin
    logic [10:0] a;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    #1 check(instr_ready_o, 1'b1);
    check(pc_o, PC_RST);
    reg_rd(REG_STATUS); check(d, STATUS_RST);
    reg_rd(REG_CTRL); check(d, 8'h00);
    reg_rd(3'h7); check(d, 8'h00);
    foreach (rows[i]) begin
      a = 11'h100 + 11'(i);
      u_mem.mem_q[a] = rows[i].v.m0;
      reg_wr(REG_ACC, rows[i].v.a0);
      reg_wr(REG_STATUS, rows[i].v.s0);
      pc0 = pc_o;
      run(rows[i].op, a, rows[i].v.imm, 14'h0000);
      check(16'(cyc), 16'(rows[i].v.cyc));
      check(16'(pc_o - pc0), 16'(rows[i].v.cyc));
      reg_rd(REG_ACC); check(d, rows[i].v.a1);
      reg_rd(REG_STATUS); check(d, rows[i].v.s1);
      check(u_mem.mem_q[a], rows[i].v.m1);
    end
    reg_wr(REG_STATUS, 8'h0f);
    run(OP_JUMP, 11'h000, 8'h00, 14'h2abc);
    check(pc_o, 14'h2abc);
    check(16'(cyc), 16'h0002);
    reg_rd(REG_STATUS); check(d, 8'h0f);
    reg_rd(REG_PC_LO); check(d, 8'hbc);
    reg_rd(REG_PC_HI); check(d, 8'h2a);
    u_mem.stk_q[0] = 14'h0789;
    u_mem.stk_q[1] = 14'h0123;
    u_mem.stk_q[2] = 14'h0456;
    u_mem.stk_q[3] = 14'h0abc;
    u_mem.sp_q = 2'h2;
    run(OP_RETURN, 11'h000, 8'h00, 14'h0000);
    check(pc_o, 14'h0456);
    run(OP_RETURN_IMM, 11'h000, 8'h77, 14'h0000);
    check(pc_o, 14'h0123);
    reg_rd(REG_ACC); check(d, 8'h77);
    reg_wr(REG_CTRL, 8'h00);
    run(OP_INTERRUPT_RETURN, 11'h000, 8'h00, 14'h0000);
    check(pc_o, 14'h0789);
    check(int_take_o, 1'b0);
    reg_rd(REG_CTRL); check(d, 8'h01);
    reg_rd(REG_STATUS); check(d, 8'h0f);
    reg_wr(REG_CTRL, 8'h00);
    int_pending_i <= 1'b1;
    run(OP_INTERRUPT_RETURN, 11'h000, 8'h00, 14'h0000);
    check(pc_o, 14'h0abc);
    check(int_take_o, 1'b1);
    // set the timeout flag first so the halt must clear it
    @(posedge clk_i);
    int_pending_i <= 1'b0;
    wdt_timeout_i <= 1'b1;
    @(posedge clk_i);
    wdt_timeout_i <= 1'b0;
    reg_wr(REG_ACC, 8'h5e);
    u_mem.mem_q[11'h020] = 8'h30;
    @(posedge clk_i);
    instr_op_i <= OP_POWER_DOWN;
    instr_valid_i <= 1'b1;
    @(posedge clk_i);
    instr_op_i <= OP_INCREMENT_MEMORY;
    instr_addr_i <= 11'h020;
    cyc = 0;
    do begin
      @(posedge clk_i);
      #1 cyc++;
    end while (sys_clk_run_o !== 1'b0 && cyc < 8);
    if (cyc >= 8) begin
      n_fail++;
      close_out();
    end
    repeat (3) @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1 check(instr_ready_o, 1'b0);
    reg_rd(REG_STATUS); check({d[ST_PDF], d[ST_TO]}, 2'b10);
    reg_rd(REG_ACC); check(d, 8'h5e);
    reg_rd(REG_CORE); check(d, 8'h08);
    check(u_mem.mem_q[11'h020], 8'h30);
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    #1 check({sys_clk_run_o, instr_ready_o}, 2'b11);
    close_out();
  end
endmodule
